// >>> sssp_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial shift port
`ifndef SSSP_CFG_SVH
`define SSSP_CFG_SVH
`define SSSP_ADDR_W        4
`define SSSP_OFF_CTRL      4'ha
`define SSSP_OFF_STAT      4'hb
`define SSSP_OFF_DATA      4'hc
`define SSSP_CTRL_IRQ_EN   7
`define SSSP_CTRL_ENABLE   6
`define SSSP_CTRL_MASTER   4
`define SSSP_CTRL_CPOL     3
`define SSSP_CTRL_CPHA     2
`define SSSP_STAT_DONE     7
`define SSSP_STAT_WRITE_COLLISION_FLAG     6
`define SSSP_STAT_MODE_FAULT_FLAG     4
`define SSSP_CTRL_RST      8'h04
`define SSSP_DIV_HALF      8'h04
`define SSSP_BITS          4'h8
`endif

// >>> sssp_pkg.sv
// Types shared by the serial shift port
package sssp_pkg;
    typedef enum logic [2:0] {
        SSSP_IDLE  = 3'b001,
        SSSP_SHIFT = 3'b010,
        SSSP_SLAVE = 3'b100
    } sssp_state_e;
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic ss_n;
    } sssp_pins_s;
endpackage

// >>> sssp_port.sv
// Serial shift port: master and slave shifting, flags and register port
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "sssp_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - One 8-bit register shifts out and in
// - Master drives the serial clock
// - Only a master starts a transfer
// - Master data write starts a transfer
// - Data write loads shifter; in master, the first clock edge follows one half period later
// - Eight serial clocks end transfer, set done
// - Received byte copied to read buffer at done
// - Done set in master and slave roles
// - Done raises interrupt when enabled
// - Done clears: status read, then data access
// - Data write during transfer sets collision
// - Collision clears: status read, then data access
// - Low slave select in master sets fault
// - Fault raises interrupt when enabled
// - Fault clears: status read, then control write
// - Reset clears all three flags
////////////////////////////////////////////////////////////////////////////////
module sssp_port (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // Register port
    input  wire logic [`SSSP_ADDR_W-1:0]   addr_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [7:0]                rdata_o,
    // Interrupt
    output logic                           irq_o,
    // Serial pins, inputs
    input  wire logic                      sclk_i,
    input  wire logic                      mosi_i,
    input  wire logic                      miso_i,
    input  wire logic                      slave_select_pin_n_i,
    // Serial pins, outputs and enables
    output sssp_pkg::sssp_pins_s           pins_o,
    output sssp_pkg::sssp_pins_s           pins_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
    logic [2:0] sclk_sy_r;          // Serial clock samples
    logic [2:0] mosi_sy_r;          // Slave data in samples
    logic [2:0] miso_sy_r;          // Master data in samples
    logic [2:0] ss_sy_r;            // Slave select samples
    logic       sclk_f_r;           // Filtered serial clock
    logic       mosi_f_r;           // Filtered slave data in
    logic       miso_f_r;           // Filtered master data in
    logic       ss_f_r;             // Filtered slave select, active low

    // Shift the samples in; stage 1 feeds only stage 2
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_sy_r <= 3'h0;
            mosi_sy_r <= 3'h0;
            miso_sy_r <= 3'h0;
            ss_sy_r   <= 3'h7;
        end else begin
            sclk_sy_r <= {sclk_sy_r[1:0], sclk_i};
            mosi_sy_r <= {mosi_sy_r[1:0], mosi_i};
            miso_sy_r <= {miso_sy_r[1:0], miso_i};
            ss_sy_r   <= {ss_sy_r[1:0], slave_select_pin_n_i};
        end
    end

    // Filtered levels follow only when the two late stages agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_f_r <= 1'b0;
            mosi_f_r <= 1'b0;
            miso_f_r <= 1'b0;
            ss_f_r   <= 1'b1;
        end else begin
            if (sclk_sy_r[2] == sclk_sy_r[1]) sclk_f_r <= sclk_sy_r[2];
            if (mosi_sy_r[2] == mosi_sy_r[1]) mosi_f_r <= mosi_sy_r[2];
            if (miso_sy_r[2] == miso_sy_r[1]) miso_f_r <= miso_sy_r[2];
            if (ss_sy_r[2] == ss_sy_r[1])     ss_f_r   <= ss_sy_r[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register and bus decode
    logic [7:0] ctrl_r;             // Serial control register
    logic       hit_ctrl_w;         // Access to control register
    logic       hit_stat_w;         // Access to status register
    logic       hit_data_w;         // Access to data register
    logic       irq_en_w;           // Interrupt enable
    logic       en_w;               // Port enable
    logic       master_select_w;    // Master role selected
    logic       cpol_w;             // Idle level of serial clock
    // Clock phase bit is stored and read back but not decoded: the engine always
    // presents data before the leading edge and moves it on the trailing edge

    assign hit_ctrl_w      = (addr_i == `SSSP_OFF_CTRL);
    assign hit_stat_w      = (addr_i == `SSSP_OFF_STAT);
    assign hit_data_w      = (addr_i == `SSSP_OFF_DATA);
    assign irq_en_w        = ctrl_r[`SSSP_CTRL_IRQ_EN];
    assign en_w            = ctrl_r[`SSSP_CTRL_ENABLE];
    assign master_select_w = ctrl_r[`SSSP_CTRL_MASTER];
    assign cpol_w          = ctrl_r[`SSSP_CTRL_CPOL];

    // Mode fault also drops the master bit, so the pins are released at once
    logic mode_fault_flag_r;
    logic fault_evt_w;
    assign fault_evt_w = en_w && master_select_w && !ss_f_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= `SSSP_CTRL_RST;
        end else if (wr_i && hit_ctrl_w) begin
            ctrl_r <= wdata_i;
        end else if (fault_evt_w) begin
            ctrl_r[`SSSP_CTRL_MASTER] <= 1'b0;
            ctrl_r[`SSSP_CTRL_ENABLE] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine
    sssp_pkg::sssp_state_e state_r;     // Engine state
    logic [7:0]            shift_r;     // Shared transmit and receive shifter
    logic [7:0]            rx_buf_r;    // Read buffer of the data register
    logic [3:0]            bit_cnt_r;   // Bits exchanged in this byte
    logic [7:0]            div_r;       // Half-period divider of master clock
    logic                  sck_r;       // Master serial clock level
    logic                  phase_r;     // Leading edge seen, trailing pending
    logic                  sample_r;    // Bit captured on leading edge
    logic                  sclk_d_r;    // Previous normalised serial clock
    logic                  done_evt_r;  // One-cycle byte complete pulse
    logic                  busy_w;      // Transfer in progress
    logic                  start_w;     // Legal master start
    logic                  slv_lead_w;  // Slave leading clock edge
    logic                  slv_trail_w; // Slave trailing clock edge
    logic                  sclk_n_w;    // Serial clock normalised to idle low

    assign busy_w   = (state_r == sssp_pkg::SSSP_SHIFT) ||
                      ((state_r == sssp_pkg::SSSP_SLAVE) && (bit_cnt_r != 4'h0));
    assign start_w  = wr_i && hit_data_w && en_w && master_select_w && !busy_w;
    assign sclk_n_w = sclk_f_r ^ cpol_w;
    assign slv_lead_w  = sclk_n_w && !sclk_d_r;
    assign slv_trail_w = !sclk_n_w && sclk_d_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_n_w;
        end
    end

    // One process walks master and slave bytes; both share one shifter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r    <= sssp_pkg::SSSP_IDLE;
            shift_r    <= 8'h00;
            bit_cnt_r  <= 4'h0;
            div_r      <= 8'h00;
            sck_r      <= 1'b0;
            phase_r    <= 1'b0;
            sample_r   <= 1'b0;
            done_evt_r <= 1'b0;
        end else begin
            done_evt_r <= 1'b0;
            case (state_r)
                sssp_pkg::SSSP_IDLE: begin
                    sck_r <= 1'b0;
                    if (start_w) begin
                        shift_r   <= wdata_i;
                        bit_cnt_r <= 4'h0;
                        div_r     <= `SSSP_DIV_HALF;
                        phase_r   <= 1'b0;
                        state_r   <= sssp_pkg::SSSP_SHIFT;
                    // A stale low select may enter for one cycle; the slave branch leaves again
                    end else if (en_w && !master_select_w && !ss_f_r) begin
                        bit_cnt_r <= 4'h0;
                        phase_r   <= 1'b0;
                        state_r   <= sssp_pkg::SSSP_SLAVE;
                    end else if (wr_i && hit_data_w && !master_select_w) begin
                        shift_r <= wdata_i;                    // Slave preload
                    end
                end
                sssp_pkg::SSSP_SHIFT: begin
                    if (!master_select_w) begin
                        state_r <= sssp_pkg::SSSP_IDLE;        // Aborted by fault
                    end else if (div_r != 8'h01) begin
                        div_r <= div_r - 8'h01;
                    end else begin
                        div_r <= `SSSP_DIV_HALF;
                        sck_r <= !sck_r;
                        // Data in is taken late in the high phase: the pin filter lags by
                        // up to five cycles, more than the four-cycle half period, so the
                        // divider must not be cut below three without moving this sample
                        if (sck_r) begin
                            shift_r   <= {shift_r[6:0], miso_f_r};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == (`SSSP_BITS - 4'h1)) begin
                                done_evt_r <= 1'b1;
                                state_r    <= sssp_pkg::SSSP_IDLE;
                            end
                        end
                    end
                end
                sssp_pkg::SSSP_SLAVE: begin
                    if (ss_f_r || master_select_w || !en_w) begin
                        bit_cnt_r <= 4'h0;
                        state_r   <= sssp_pkg::SSSP_IDLE;
                    end else if (wr_i && hit_data_w && bit_cnt_r == 4'h0 && !phase_r) begin
                        shift_r <= wdata_i;
                    end else if (slv_lead_w) begin
                        sample_r <= mosi_f_r;
                        phase_r  <= 1'b1;
                    end else if (slv_trail_w && phase_r) begin
                        phase_r   <= 1'b0;
                        shift_r   <= {shift_r[6:0], sample_r};
                        if (bit_cnt_r == (`SSSP_BITS - 4'h1)) begin
                            bit_cnt_r  <= 4'h0;
                            done_evt_r <= 1'b1;
                        end else begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                default: begin
                    state_r <= sssp_pkg::SSSP_IDLE;
                end
            endcase
        end
    end

    // Received byte moves to the read buffer on the done pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_buf_r <= 8'h00;
        end else if (done_evt_r) begin
            rx_buf_r <= shift_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags with two-step clear; a new event beats a same-cycle clear
    logic xfer_done_flag_r;         // Byte complete
    logic write_collision_flag_r;   // Data write during transfer
    logic done_seen_r;              // Status read saw done set
    logic write_collision_flag_seen_r;              // Status read saw collision set
    logic mode_fault_flag_seen_r;              // Status read saw fault set
    logic stat_rd_w;                // Status register read
    logic data_acc_w;               // Data register read or write
    logic write_collision_flag_evt_w;               // Collision event

    assign stat_rd_w  = rd_i && hit_stat_w;
    assign data_acc_w = (rd_i || wr_i) && hit_data_w;
    assign write_collision_flag_evt_w = wr_i && hit_data_w && busy_w;

    // Remember what the last status read showed, armed until the follow-up access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_seen_r <= 1'b0;
            write_collision_flag_seen_r <= 1'b0;
            mode_fault_flag_seen_r <= 1'b0;
        end else begin
            if (stat_rd_w) begin
                done_seen_r <= xfer_done_flag_r;
                write_collision_flag_seen_r <= write_collision_flag_r;
                mode_fault_flag_seen_r <= mode_fault_flag_r;
            end else begin
                if (data_acc_w) done_seen_r <= 1'b0;
                if (data_acc_w) write_collision_flag_seen_r <= 1'b0;
                if (wr_i && hit_ctrl_w) mode_fault_flag_seen_r <= 1'b0;
            end
        end
    end

    // Flags: reset clears them, bus writes to status never touch them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xfer_done_flag_r       <= 1'b0;
            write_collision_flag_r <= 1'b0;
            mode_fault_flag_r      <= 1'b0;
        end else begin
            if (done_evt_r) xfer_done_flag_r <= 1'b1;
            else if (done_seen_r && data_acc_w) xfer_done_flag_r <= 1'b0;
            if (write_collision_flag_evt_w) write_collision_flag_r <= 1'b1;
            else if (write_collision_flag_seen_r && data_acc_w) write_collision_flag_r <= 1'b0;
            if (fault_evt_w) mode_fault_flag_r <= 1'b1;
            else if (mode_fault_flag_seen_r && wr_i && hit_ctrl_w) mode_fault_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i && hit_ctrl_w) begin
            rdata_o <= ctrl_r;
        end else if (stat_rd_w) begin
            rdata_o <= {xfer_done_flag_r, write_collision_flag_r, 1'b0,
                        mode_fault_flag_r, 4'h0};
        end else if (rd_i && hit_data_w) begin
            rdata_o <= rx_buf_r;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // Interrupt: level while done or fault stands with the enable set
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_en_w && (xfer_done_flag_r || mode_fault_flag_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers: master owns clock and data out; slave drives its data out
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pins_o    <= '0;
            pins_oe_o <= '0;
        end else begin
            pins_o.sclk    <= sck_r ^ cpol_w;
            pins_o.mosi    <= shift_r[7];
            pins_o.miso    <= shift_r[7];
            pins_o.ss_n    <= 1'b1;
            pins_oe_o.sclk <= en_w && master_select_w;
            pins_oe_o.mosi <= en_w && master_select_w;
            pins_oe_o.miso <= en_w && !master_select_w && (state_r == sssp_pkg::SSSP_SLAVE);
            pins_oe_o.ss_n <= 1'b0;
        end
    end

endmodule // sssp_port

// >>> sssp_port_asserts.sv
// Concurrent checks on the ports of the serial shift port
`timescale 1ns/1ps
`include "sssp_cfg.svh"
module sssp_port_asserts (
    // Clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_n_i,
    // Register port
    input wire logic [`SSSP_ADDR_W-1:0] addr_i,
    input wire logic [7:0]              wdata_i,
    input wire logic                    wr_i,
    input wire logic                    rd_i,
    input wire logic [7:0]              rdata_o,
    input wire logic                    irq_o,
    // Serial pins
    input wire logic                    sclk_i,
    input wire logic                    mosi_i,
    input wire logic                    miso_i,
    input wire logic                    slave_select_pin_n_i,
    input wire sssp_pkg::sssp_pins_s    pins_o,
    input wire sssp_pkg::sssp_pins_s    pins_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       irq_en_r;  // Shadow of the interrupt enable bit
    logic [3:0] ss_hi_r;   // Saturating count of cycles with select high
    logic [3:0] ss_lo_r;   // Saturating count of cycles with select low
    ////////////////////////////////////////////////////////////////////////////
    // Shadow enable: a fault clears only the master and enable bits, so bit 7 follows writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) irq_en_r <= 1'b0;
        else if (wr_i && addr_i == `SSSP_OFF_CTRL) irq_en_r <= wdata_i[7];
    end
    // Select counters give the filter a fixed allowance instead of exact latency
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ss_hi_r <= 4'h0;
            ss_lo_r <= 4'h0;
        end else begin
            ss_hi_r <= !slave_select_pin_n_i ? 4'h0 : (ss_hi_r == 4'hf ? ss_hi_r : ss_hi_r + 4'h1);
            ss_lo_r <= slave_select_pin_n_i ? 4'h0 : (ss_lo_r == 4'hf ? ss_lo_r : ss_lo_r + 4'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    stat_rsvd_a: assert property ($past(rd_i) && $past(addr_i) == `SSSP_OFF_STAT |->
        rdata_o[5] == 1'b0 && rdata_o[3:0] == 4'h0) else $error("status spare bits set");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside read answer");
    sclk_owner_a: assert property ($changed(pins_o.sclk) |-> pins_oe_o.sclk)
        else $error("serial clock moved while not driven");
    sclk_half_a: assert property ($rose(pins_o.sclk) |-> pins_o.sclk [*4])
        else $error("serial clock high phase short");
    mosi_hold_a: assert property ($rose(pins_o.sclk) && pins_oe_o.mosi |-> $stable(pins_o.mosi))
        else $error("data out moved at rising clock");
    irq_gate_a: assert property ($rose(irq_o) |-> $past(irq_en_r))
        else $error("interrupt with enable off");
    oe_master_a: assert property (pins_oe_o.sclk |-> pins_oe_o.mosi && !pins_oe_o.miso)
        else $error("master pin drive wrong");
    oe_slave_a: assert property (pins_oe_o.miso |-> ss_hi_r < 4'h8 && !pins_oe_o.sclk)
        else $error("slave drives data while unselected");
    fault_stop_a: assert property (ss_lo_r >= 4'h8 |-> !pins_oe_o.sclk)
        else $error("master kept clock with select low");
    ////////////////////////////////////////////////////////////////////////////
    master_xfer_c: cover property ($rose(irq_o) && pins_oe_o.mosi);
    fault_seen_c: cover property (ss_lo_r == 4'h8 && irq_o);
    slave_xfer_c: cover property (pins_oe_o.miso && $rose(sclk_i));
endmodule // sssp_port_asserts
bind sssp_port sssp_port_asserts i_sssp_port_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .sclk_i(sclk_i), .mosi_i(mosi_i), .miso_i(miso_i),
    .slave_select_pin_n_i(slave_select_pin_n_i), .pins_o(pins_o), .pins_oe_o(pins_oe_o));

// >>> sssp_peer.sv
// Serial peripheral model answering the port in master mode
`timescale 1ns/1ps
module sssp_peer (
    // Serial side
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Bench side
    input  wire logic       load_i,
    input  wire logic [7:0] byte_i,
    output logic [7:0]      rx_o
);
    logic [7:0] tx_r = 8'h00;  // Outgoing bits, MSB first
    logic [7:0] rx_r = 8'h00;  // Captured bits
    // Shift on falling clock; inverted refill so an idle line never repeats old data
    always @(negedge sclk_i or posedge load_i) begin
        if (load_i) tx_r <= byte_i;
        else tx_r <= {tx_r[6:0], ~tx_r[7]};
    end
    // Capture on rising clock
    always @(posedge sclk_i) begin
        rx_r <= {rx_r[6:0], mosi_i};
    end
    assign miso_o = tx_r[7];
    assign rx_o   = rx_r;
endmodule // sssp_peer

// >>> tb_sync_serial_shift_port.sv
// Self-checking bench of the serial shift port
`timescale 1ns/1ps
`include "sssp_cfg.svh"
module tb_sync_serial_shift_port;
    logic                 clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0]           addr_i = 4'h0;
    logic [7:0]           wdata_i = 8'h00, rdata_o, peer_rx, peer_byte = 8'h00, tx, rx, got;
    logic                 irq_o, miso_i, sclk_i = 1'b0, mosi_i = 1'b0, ss_n = 1'b1;
    logic                 peer_load = 1'b0, rd_d = 1'b0;
    sssp_pkg::sssp_pins_s pins_o, pins_oe_o;
    logic [7:0]           exp_q[$];  // Expected read answers, oldest first
    int                   err_count = 0, comparisons = 0;
    initial forever #5 clk_i = ~clk_i;
    sssp_port i_sssp_port (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .sclk_i(sclk_i), .mosi_i(mosi_i), .miso_i(miso_i), .slave_select_pin_n_i(ss_n),
        .pins_o(pins_o), .pins_oe_o(pins_oe_o));
    sssp_peer i_sssp_peer (.sclk_i(pins_o.sclk), .mosi_i(pins_o.mosi), .miso_o(miso_i),
        .load_i(peer_load), .byte_i(peer_byte), .rx_o(peer_rx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // One strobe cycle then one idle cycle, so no signal is assigned twice in a step
    task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= r;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(a, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq_o !== 1'b1; i++) @(posedge clk_i);
        check("irq_o", 8'h01, {7'h00, irq_o});
    endtask
    // External master at 80 ns per bit; miso read at the end of the high phase
    task automatic slave_xfer(input logic [7:0] m, input logic sel, output logic [7:0] g);
        ss_n <= ~sel;
        repeat (8) @(posedge clk_i);
        for (int i = 7; i >= 0; i--) begin
            mosi_i <= m[i];
            repeat (4) @(posedge clk_i);
            sclk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            g[i] = pins_o.miso;
            sclk_i <= 1'b0;
        end
        repeat (8) @(posedge clk_i);
        ss_n <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Read answer monitor: settled value at the falling edge of the answer cycle
    always @(posedge clk_i) rd_d <= rd_i;
    always @(negedge clk_i) begin
        if (rd_d === 1'b1) check("rdata_o", exp_q.pop_front(), rdata_o);
    end
    // Watchdog well beyond the expected run of a few hundred cycles
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'he812c7c0));
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(`SSSP_OFF_STAT, 8'h00);
        rd(`SSSP_OFF_CTRL, `SSSP_CTRL_RST);
        bus(`SSSP_OFF_STAT, 8'hff, 1'b1, 1'b0);
        rd(`SSSP_OFF_STAT, 8'h00);
        bus(`SSSP_OFF_CTRL, 8'hd0, 1'b1, 1'b0);
        // Plain master transfer, then one with a colliding second write
        for (int n = 0; n < 2; n++) begin
            tx = 8'($urandom);
            rx = 8'($urandom);
            peer_byte <= rx;
            peer_load <= 1'b1;
            @(posedge clk_i);
            peer_load <= 1'b0;
            bus(`SSSP_OFF_DATA, tx, 1'b1, 1'b0);
            if (n == 1) bus(`SSSP_OFF_DATA, ~tx, 1'b1, 1'b0);
            wait_irq(200);
            check("peer_rx", tx, peer_rx);
            rd(`SSSP_OFF_STAT, n == 1 ? 8'hc0 : 8'h80);
            rd(`SSSP_OFF_DATA, rx);
            rd(`SSSP_OFF_STAT, 8'h00);
            check("irq_clear", 8'h00, {7'h00, irq_o});
        end
        // Mode fault from a low select while master
        ss_n <= 1'b0;
        wait_irq(30);
        rd(`SSSP_OFF_STAT, 8'h10);
        ss_n <= 1'b1;
        rd(`SSSP_OFF_CTRL, 8'h80);
        bus(`SSSP_OFF_CTRL, 8'h40, 1'b1, 1'b0);
        rd(`SSSP_OFF_STAT, 8'h00);
        // Slave: preload, idle wait, unselected clocks, then a real frame
        tx = 8'($urandom);
        rx = 8'($urandom);
        bus(`SSSP_OFF_DATA, tx, 1'b1, 1'b0);
        repeat (40) @(posedge clk_i);
        rd(`SSSP_OFF_STAT, 8'h00);
        slave_xfer(rx, 1'b0, got);
        rd(`SSSP_OFF_STAT, 8'h00);
        slave_xfer(rx, 1'b1, got);
        check("slave_miso", tx, got);
        check("irq_masked", 8'h00, {7'h00, irq_o});
        rd(`SSSP_OFF_STAT, 8'h80);
        rd(`SSSP_OFF_DATA, rx);
        // Done flag set again, then cleared by a reset in mid-run
        slave_xfer(~rx, 1'b1, got);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(`SSSP_OFF_STAT, 8'h00);
        repeat (4) @(posedge clk_i);
        report_and_stop();
    end
endmodule // tb_sync_serial_shift_port
